//--- mra_pkg.sv
`default_nettype none
package mra_pkg;
	// Register byte offsets
	localparam logic [3:0] OFF_REGION_REGION_START_ADDR   = 4'h0;
	localparam logic [3:0] OFF_REGION_ACCESS = 4'h4;
	localparam logic [3:0] OFF_CORE_CONFIG   = 4'h8;
	localparam logic [3:0] OFF_UNIT_STATUS   = 4'hc;
	// Region region_start_addr register fields
	localparam int IDX_LSB   = 0;
	localparam int D_BIT     = 4;
	localparam int START_LSB = 6;
	localparam int START_W   = 26;
	// Region access register fields
	localparam int WR_BIT    = 0;
	localparam int RD_BIT    = 1;
	localparam int PERMISSION_FIELD_LSB  = 2;
	localparam int PERMISSION_FIELD_W    = 3;
	localparam int C_BIT     = 5;
	localparam int MASKL_LSB = 6;
	// Core configuration fields
	localparam int PE_BIT    = 0;
	localparam int LIM_BIT   = 1;
	// Status fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_DEBUG  = 1;
	localparam int ST_STALE  = 2;
	localparam int ST_OFF    = 3;
	// Region count and stored entry layout
	localparam int REGION_IDX_W = 4;
	localparam int ENTRY_W      = 2 * START_W + 1 + PERMISSION_FIELD_W;
	// Reset values
	localparam logic [31:0] RST_REGION_REGION_START_ADDR   = 32'h0000_0000;
	localparam logic [31:0] RST_REGION_ACCESS = 32'h0000_0000;
	localparam logic [1:0]  RST_CORE_CONFIG   = 2'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Write path states
	typedef enum logic [1:0] {
		WS_IDLE = 2'b00,
		WS_LOAD = 2'b01,
		WS_RESP = 2'b10
	} mra_wstate_e;
endpackage
`default_nettype wire

//--- mra_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mra_mem_if #(parameter int AW = 5, parameter int DW = 56);
	logic          we;    // Store strobe
	logic [AW-1:0] waddr; // Store slot
	logic [DW-1:0] wdata; // Attributes to store
	logic          re;    // Load strobe
	logic [AW-1:0] raddr; // Load slot
	logic [DW-1:0] rdata; // Registered load data
	modport ctl (output we, waddr, wdata, re, raddr, input rdata);
	modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

//--- mra_region_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mra_region_mem #(
	parameter int AW = 5,
	parameter int DW = 56
) (
	// Clock
	input wire logic i_core_clk,
	// Port
	mra_mem_if.mem   port
);
	// Attribute store, one word per region slot
	logic [DW-1:0] store [2**AW];
	logic [DW-1:0] rdata_q; // Registered read data

	// Write and registered read; no reset so it maps to block memory
	always_ff @(posedge i_core_clk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
		if (port.re) begin
			rdata_q <= store[port.raddr];
		end
	end

	assign port.rdata = rdata_q;
endmodule // mra_region_mem
`default_nettype wire

//--- mra_region_access.sv
`timescale 1ns/100ps
`default_nettype none
module mra_region_access
	import mra_pkg::*;
#(
	parameter int IDX_W = REGION_IDX_W
) (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	// AXI4-Lite write address and data
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_awaddr,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	// AXI4-Lite write response
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	output logic [1:0]       o_s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	input  wire logic [31:0] i_s_axi_araddr,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	// Core side
	input  wire logic        i_debug_mode,
	input  wire logic        i_flushp,
	output logic             o_pipe_flush,
	output logic             o_prot_active,
	output logic             o_limit_mode,
	output logic             o_regions_stale
);
	localparam int AW = IDX_W + 1;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	// Disabled-region test, used only by the status read; the enable path does not use it
	function automatic logic region_off(input logic [31:0] b, input logic [31:0] a,
		input logic lim);
		logic [START_W-1:0] st;
		logic [START_W-1:0] ml;
		st = b[START_LSB +: START_W];
		ml = a[MASKL_LSB +: START_W];
		region_off = lim ? ((st != '0) && (ml == '0)) : (ml == '0);
	endfunction

	// Slot address from the index and selector held in region_start_addr
	function automatic logic [AW-1:0] slot(input logic [31:0] b);
		slot = {b[D_BIT], b[IDX_LSB +: IDX_W]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	mra_wstate_e st, next_st;           // Write path state
	logic        aw_held, next_aw_held; // Write address captured
	logic        w_held, next_w_held;   // Write data captured
	logic [3:0]  wa, next_wa;           // Captured write offset
	logic [31:0] wd, next_wd;           // Captured write data
	logic        wfull, next_wfull;     // Captured strobes all set
	logic [1:0]  bresp, next_bresp;     // Pending write response
	logic [31:0] region_start_addr_q, next_region_start_addr;     // Region region_start_addr register
	logic [31:0] acc_q, next_acc;       // Region access register
	logic [1:0]  cfg_q, next_cfg;       // Core configuration
	logic        flush_q, next_flush;   // Pipeline flush pulse
	logic        stale_q, next_stale;   // Region writes awaiting a flush
	logic        active_q, next_active; // Checks in force
	logic        rvalid_q, next_rvalid; // Read answer pending
	logic [31:0] rdata_q, next_rdata;   // Read answer data
	logic [1:0]  rresp_q, next_rresp;   // Read answer response
	logic        exec;                  // Captured write executes now
	logic        ld_flag, sr_flag;      // Decoded access flags

	mra_mem_if #(.AW(AW), .DW(ENTRY_W)) mem_bus ();

	mra_region_mem #(.AW(AW), .DW(ENTRY_W)) u_mem (
		.i_core_clk (i_core_clk),
		.port       (mem_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Write path: capture, execute, respond
	// Address and data may arrive in either order; nothing new is taken
	// until the response has been accepted, so one write is under way.
	always_comb begin
		next_st      = st;
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wa      = wa;
		next_wd      = wd;
		next_wfull   = wfull;
		next_bresp   = bresp;
		next_region_start_addr    = region_start_addr_q;
		next_acc     = acc_q;
		next_cfg     = cfg_q;
		next_flush   = 1'b0;
		next_stale   = stale_q;
		mem_bus.we    = 1'b0;
		mem_bus.waddr = slot(region_start_addr_q);
		mem_bus.wdata = {region_start_addr_q[START_LSB +: START_W], wd[MASKL_LSB +: START_W],
			wd[C_BIT], wd[PERMISSION_FIELD_LSB +: PERMISSION_FIELD_W]};
		mem_bus.re    = 1'b0;
		mem_bus.raddr = slot(region_start_addr_q);
		exec    = aw_held && w_held && (st == WS_IDLE);
		ld_flag = wd[RD_BIT] && !wd[WR_BIT];
		sr_flag = wd[WR_BIT] && !wd[RD_BIT];
		// Capture address and data
		if (o_s_axi_awready && i_s_axi_awvalid) begin
			next_aw_held = 1'b1;
			next_wa      = i_s_axi_awaddr[3:0];
		end
		if (o_s_axi_wready && i_s_axi_wvalid) begin
			next_w_held = 1'b1;
			next_wd     = i_s_axi_wdata;
			// Strobes belong to the data beat and may change once it is taken
			next_wfull  = (i_s_axi_wstrb == 4'hf);
		end
		// Explicit flush or a flushing write retires staged region writes
		if (flush_q || i_flushp) begin
			next_stale = 1'b0;
		end
		case (st)
			WS_IDLE: begin
				if (exec) begin
					next_st    = WS_RESP;
					next_bresp = RESP_OKAY;
					// Partial strobes are refused rather than merged
					if (!wfull || (wa[1:0] != 2'h0)) begin
						next_bresp = RESP_SLVERR;
					end else begin
						case (wa)
							OFF_REGION_REGION_START_ADDR: begin
								// Selection only; no fetch here
								next_region_start_addr = wd & ~32'h0000_0020;
							end
							OFF_REGION_ACCESS: begin
								if (ld_flag) begin
									mem_bus.re = 1'b1;
									next_st    = WS_LOAD;
								end else if (sr_flag) begin
									mem_bus.we = 1'b1;
									next_acc   = wd & ~32'h0000_0003;
									next_stale = 1'b1;
								end else if (!wd[RD_BIT]) begin
									next_acc = wd;
								end
								// Both flags set: ignored, nothing changes
							end
							OFF_CORE_CONFIG: begin
								next_cfg   = wd[1:0];
								next_flush = 1'b1;
							end
							default: begin
								next_bresp = RESP_SLVERR;
							end
						endcase
					end
				end
			end
			WS_LOAD: begin
				// Both registers change in one edge, never half-loaded
				next_region_start_addr[START_LSB +: START_W] =
					mem_bus.rdata[ENTRY_W-1 -: START_W];
				next_acc = {mem_bus.rdata[PERMISSION_FIELD_W+1 +: START_W],
					mem_bus.rdata[PERMISSION_FIELD_W], mem_bus.rdata[PERMISSION_FIELD_W-1:0],
					2'b00};
				next_st = WS_RESP;
			end
			WS_RESP: begin
				if (i_s_axi_bready) begin
					next_st      = WS_IDLE;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
				end
			end
			default: begin
				next_st = WS_IDLE;
			end
		endcase
	end

	// Write path registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st      <= WS_IDLE;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wa      <= 4'h0;
			wd      <= 32'h0000_0000;
			wfull   <= 1'b0;
			bresp   <= RESP_OKAY;
			region_start_addr_q  <= RST_REGION_REGION_START_ADDR;
			acc_q   <= RST_REGION_ACCESS;
			cfg_q   <= RST_CORE_CONFIG;
			flush_q <= 1'b0;
			stale_q <= 1'b0;
		end else begin
			st      <= next_st;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			wa      <= next_wa;
			wd      <= next_wd;
			wfull   <= next_wfull;
			bresp   <= next_bresp;
			region_start_addr_q  <= next_region_start_addr;
			acc_q   <= next_acc;
			cfg_q   <= next_cfg;
			flush_q <= next_flush;
			stale_q <= next_stale;
		end
	end

	assign o_s_axi_awready = !aw_held;
	assign o_s_axi_wready  = !w_held;
	assign o_s_axi_bvalid  = (st == WS_RESP);
	assign o_s_axi_bresp   = bresp;

	////////////////////////////////////////////////////////////////////////
	// Read path and protection state
	// Read access is never gated by debug mode, so a debugger sees every register
	always_comb begin
		next_rvalid = rvalid_q;
		next_rdata  = rdata_q;
		next_rresp  = rresp_q;
		// Debug bypass is a plain gate: regions keep their contents
		next_active = cfg_q[PE_BIT] && !i_debug_mode;
		if (rvalid_q && i_s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (o_s_axi_arready && i_s_axi_arvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (i_s_axi_araddr[3:0])
				OFF_REGION_REGION_START_ADDR:   next_rdata = region_start_addr_q;
				OFF_REGION_ACCESS: next_rdata = acc_q;
				OFF_CORE_CONFIG:   next_rdata = {30'h0, cfg_q};
				OFF_UNIT_STATUS: begin
					next_rdata = 32'h0000_0000;
					next_rdata[ST_ACTIVE] = active_q;
					next_rdata[ST_DEBUG]  = i_debug_mode;
					next_rdata[ST_STALE]  = stale_q;
					next_rdata[ST_OFF]    = region_off(region_start_addr_q, acc_q,
						cfg_q[LIM_BIT]);
				end
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	// Read path registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
			active_q <= 1'b0;
		end else begin
			rvalid_q <= next_rvalid;
			rdata_q  <= next_rdata;
			rresp_q  <= next_rresp;
			active_q <= next_active;
		end
	end

	assign o_s_axi_arready = !rvalid_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rdata   = rdata_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_pipe_flush    = flush_q;
	assign o_prot_active   = active_q;
	assign o_limit_mode    = cfg_q[LIM_BIT];
	assign o_regions_stale = stale_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	logic ok_w;  // Full-word write to an aligned offset
	assign ok_w = wfull && (wa[1:0] == 2'h0);

	sequence s_load_issue;
		exec && ok_w && (wa == OFF_REGION_ACCESS) && ld_flag;
	endsequence
	sequence s_load_done;
		(st == WS_LOAD) ##1 o_s_axi_bvalid;
	endsequence

	property p_load_seq;
		s_load_issue |=> s_load_done;
	endproperty
	a_load_seq: assert property (p_load_seq)
		else $error("load did not answer two cycles after issue");

	property p_load_copy;
		(st == WS_LOAD) |=> (acc_q[MASKL_LSB +: START_W] ==
			$past(mem_bus.rdata[PERMISSION_FIELD_W+1 +: START_W])) && (acc_q[1:0] == 2'b00);
	endproperty
	a_load_copy: assert property (p_load_copy)
		else $error("access register not loaded from region");

	property p_region_start_addr_no_fetch;
		exec && (wa == OFF_REGION_REGION_START_ADDR) |-> !mem_bus.re && !mem_bus.we;
	endproperty
	a_region_start_addr_no_fetch: assert property (p_region_start_addr_no_fetch)
		else $error("region_start_addr write touched region store");

	property p_store_slot;
		exec && ok_w && (wa == OFF_REGION_ACCESS) && sr_flag
			|-> mem_bus.we && (mem_bus.waddr == {region_start_addr_q[D_BIT], region_start_addr_q[IDX_W-1:0]});
	endproperty
	a_store_slot: assert property (p_store_slot)
		else $error("store missed the selected region");

	property p_cfg_flush;
		exec && ok_w && (wa == OFF_CORE_CONFIG)
			|=> o_pipe_flush && (cfg_q[PE_BIT] == $past(wd[PE_BIT]));
	endproperty
	a_cfg_flush: assert property (p_cfg_flush)
		else $error("config write did not flush or enable");

	property p_region_no_flush;
		exec && ((wa == OFF_REGION_REGION_START_ADDR) || (wa == OFF_REGION_ACCESS)) |=> !o_pipe_flush;
	endproperty
	a_region_no_flush: assert property (p_region_no_flush)
		else $error("region write flushed the pipeline");

	property p_stale_clear;
		i_flushp && !(exec && (wa == OFF_REGION_ACCESS) && sr_flag) |=> !o_regions_stale;
	endproperty
	a_stale_clear: assert property (p_stale_clear)
		else $error("flush left region writes stale");

	property p_debug_bypass;
		i_debug_mode [*2] |-> !o_prot_active;
	endproperty
	a_debug_bypass: assert property (p_debug_bypass)
		else $error("checks active during debug");

	property p_plain_access;
		exec && ok_w && (wa == OFF_REGION_ACCESS) && !wd[RD_BIT] && !wd[WR_BIT]
			|-> !mem_bus.we && !mem_bus.re ##1 (acc_q == $past(wd));
	endproperty
	a_plain_access: assert property (p_plain_access)
		else $error("flagless access write reached the store");
endmodule // mra_region_access
`default_nettype wire

//--- mra_region_access_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mra_region_access_tb;
	import mra_pkg::*;
	// Byte addresses of the registers, widened to the bus width
	localparam logic [31:0] A_REGION_START_ADDR = {28'h0, OFF_REGION_REGION_START_ADDR};
	localparam logic [31:0] A_ACC  = {28'h0, OFF_REGION_ACCESS};
	localparam logic [31:0] A_CFG  = {28'h0, OFF_CORE_CONFIG};
	localparam logic [31:0] A_STAT = {28'h0, OFF_UNIT_STATUS};
	// Attribute sets for two regions sharing one index
	localparam logic [25:0] S_A = 26'h0123456;
	localparam logic [25:0] M_A = 26'h0000fff;
	localparam logic [25:0] S_B = 26'h2abcdef;
	localparam logic [25:0] M_B = 26'h00000ff;
	// Clock, reset and bus signals
	logic        clk, rst_b;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	// Core side signals
	logic        dbg, flushp, pflush, active, limit, stale;
	// Scoreboard counters
	int          errors, n_tests;
	int          n_flush = 0; // Flush pulses seen
	mra_region_access u_dut (
		.i_core_clk(clk), .i_rst_b(rst_b),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_debug_mode(dbg),
		.i_flushp(flushp), .o_pipe_flush(pflush), .o_prot_active(active),
		.o_limit_mode(limit), .o_regions_stale(stale)
	);
	//////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Counts flush pulses; a level that sticks shows up as an excess count
	always @(posedge clk) begin
		if (pflush === 1'b1) n_flush <= n_flush + 1;
	end
	//////////////////////////////////////////////////////////////////////////////
	// Compare one value and report a mismatch at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Region_start_addr register image: start, data selector, index
	function automatic logic [31:0] mkb(logic [25:0] s, logic d, logic [3:0] ix);
		return {s, 1'b0, d, ix};
	endfunction
	// Access register image: mask or limit, cacheable, permission, load and store
	function automatic logic [31:0] mka(logic [25:0] m, logic c, logic [2:0] p, logic [1:0] f);
		return {m, c, p, f};
	endfunction
	// Bus write; address and data are offered together and released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk({30'h0, bresp}, {30'h0, er}, "write response");
				chk({30'h0, awready, wready}, 32'h0, "readies while answering");
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// Bus read; rready stays high until the data comes
	task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk(rdata, ed, "read data");
				chk({30'h0, rresp}, {30'h0, er}, "read response");
				chk({31'h0, arready}, 32'h0, "arready while answering");
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// Let registered core-side outputs land before looking at them
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Prints the counts and the verdict, then ends the run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		errors = 0; n_tests = 0;
		rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0; wstrb = 4'hf;
		dbg = 1'b0; flushp = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		// Disabled out of reset, registers at their reset values
		rd(A_CFG, 32'h0, RESP_OKAY);
		rd(A_REGION_START_ADDR, RST_REGION_REGION_START_ADDR, RESP_OKAY);
		rd(A_ACC, RST_REGION_ACCESS, RESP_OKAY);
		chk({31'h0, active}, 32'h0, "active after reset");
		// Two stores to the same index, told apart by the selector
		wr(A_REGION_START_ADDR, mkb(S_A, 1'b1, 4'h3), RESP_OKAY);
		wr(A_ACC, mka(M_A, 1'b1, 3'h6, 2'b01), RESP_OKAY);
		wr(A_REGION_START_ADDR, mkb(S_B, 1'b0, 4'h3), RESP_OKAY);
		wr(A_ACC, mka(M_B, 1'b0, 3'h3, 2'b01), RESP_OKAY);
		settle();
		chk({31'h0, stale}, 32'h1, "stale after store");
		chk(n_flush, 32'h0, "flush on region writes");
		rd(A_ACC, mka(M_B, 1'b0, 3'h3, 2'b00), RESP_OKAY);
		// Selecting alone fetches nothing
		wr(A_REGION_START_ADDR, mkb(26'h0, 1'b1, 4'h3), RESP_OKAY);
		rd(A_REGION_START_ADDR, mkb(26'h0, 1'b1, 4'h3), RESP_OKAY);
		// Load brings the stored attributes into both registers
		wr(A_ACC, mka(26'h0, 1'b0, 3'h0, 2'b10), RESP_OKAY);
		rd(A_REGION_START_ADDR, mkb(S_A, 1'b1, 4'h3), RESP_OKAY);
		rd(A_ACC, mka(M_A, 1'b1, 3'h6, 2'b00), RESP_OKAY);
		wr(A_REGION_START_ADDR, mkb(26'h0, 1'b0, 4'h3), RESP_OKAY);
		wr(A_ACC, mka(26'h0, 1'b0, 3'h0, 2'b10), RESP_OKAY);
		rd(A_REGION_START_ADDR, mkb(S_B, 1'b0, 4'h3), RESP_OKAY);
		// Neither flag: register only, the stored region is untouched
		wr(A_ACC, mka(26'h1234, 1'b1, 3'h5, 2'b00), RESP_OKAY);
		rd(A_ACC, mka(26'h1234, 1'b1, 3'h5, 2'b00), RESP_OKAY);
		wr(A_ACC, mka(26'h0, 1'b0, 3'h0, 2'b10), RESP_OKAY);
		rd(A_ACC, mka(M_B, 1'b0, 3'h3, 2'b00), RESP_OKAY);
		// Config write flushes once and turns protection on
		wr(A_CFG, 32'h1, RESP_OKAY);
		settle();
		chk(n_flush, 32'h1, "config flush count");
		chk({31'h0, stale}, 32'h0, "stale after config flush");
		chk({31'h0, active}, 32'h1, "active after enable");
		rd(A_STAT, 32'h1, RESP_OKAY);
		// Debug bypass; registers stay reachable meanwhile
		@(posedge clk);
		dbg <= 1'b1;
		settle();
		chk({31'h0, active}, 32'h0, "active in debug");
		rd(A_STAT, 32'h2, RESP_OKAY);
		rd(A_CFG, 32'h1, RESP_OKAY);
		wr(A_REGION_START_ADDR, mkb(26'h0, 1'b0, 4'h5), RESP_OKAY);
		@(posedge clk);
		dbg <= 1'b0;
		settle();
		chk({31'h0, active}, 32'h1, "active after debug");
		// Store a zero mask, then the explicit flush clears stale
		wr(A_ACC, mka(26'h0, 1'b1, 3'h7, 2'b01), RESP_OKAY);
		rd(A_STAT, 32'hd, RESP_OKAY);
		@(posedge clk);
		flushp <= 1'b1;
		@(posedge clk);
		flushp <= 1'b0;
		settle();
		chk({31'h0, stale}, 32'h0, "stale after flush pulse");
		// Limit mode: zero limit disables only with a nonzero start
		wr(A_CFG, 32'h3, RESP_OKAY);
		settle();
		chk({31'h0, limit}, 32'h1, "limit mode");
		chk(n_flush, 32'h2, "second config flush");
		rd(A_STAT, 32'h1, RESP_OKAY);
		wr(A_REGION_START_ADDR, mkb(26'h40, 1'b0, 4'h5), RESP_OKAY);
		rd(A_STAT, 32'h9, RESP_OKAY);
		// Context switch step: disable again
		wr(A_CFG, 32'h0, RESP_OKAY);
		settle();
		chk({31'h0, active}, 32'h0, "active after disable");
		// Refused accesses
		wr(32'h6, 32'h1, RESP_SLVERR);
		rd(32'h6, 32'h0, RESP_SLVERR);
		wr(A_STAT, 32'hf, RESP_SLVERR);
		rd(A_CFG, 32'h0, RESP_OKAY);
		stop_test();
	end
endmodule // mra_region_access_tb
`default_nettype wire
